// *** core/asf_pkg.sv ***
// Shared constants for the asynchronous response and stream transmit formatter
package asf_pkg;

   // ----------------------------------------------------------------
   // Transaction codes and fixed field values
   // ----------------------------------------------------------------
   localparam logic [3:0] TC_QUAD_RESP = 4'h6;
   localparam logic [3:0] TC_BLOCK_RESP = 4'h7;
   localparam logic [3:0] TC_LOCK_RESP = 4'hb;
   localparam logic [3:0] TC_STREAM = 4'ha;
   localparam logic [1:0] RETRY_X = 2'b01;
   localparam logic [9:0] BUS_LOCAL = 10'h3ff;
   localparam logic [3:0] PRIORITY_ZERO = 4'h0;

   // ----------------------------------------------------------------
   // Speed codes and link rate encodings
   // ----------------------------------------------------------------
   localparam logic [2:0] SPD_100 = 3'h0;
   localparam logic [2:0] SPD_200 = 3'h1;
   localparam logic [2:0] SPD_400 = 3'h2;
   localparam logic [1:0] RATE_100 = 2'h0;
   localparam logic [1:0] RATE_200 = 2'h1;
   localparam logic [1:0] RATE_400 = 2'h2;

   // ----------------------------------------------------------------
   // Internal transmit format: field positions
   // ----------------------------------------------------------------
   localparam int Q0_SRCSEL = 23;
   localparam int Q0_SPD_LSB = 16;
   localparam int Q0_TRANSACTION_LABEL_LSB = 10;
   localparam int Q0_RT_LSB = 8;
   localparam int Q0_TCODE_LSB = 4;
   localparam int Q0_TAG_LSB = 14;
   localparam int Q0_CHAN_LSB = 8;
   localparam int Q0_SYNC_LSB = 0;
   localparam int Q1_TARGET_LSB = 16;
   localparam int Q1_RESPONSE_CODE_LSB = 12;
   localparam int LEN_LSB = 16;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_NODE = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_COUNT = 8'h0c;
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_RETRY_SUB = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   localparam int STAT_BUSY = 0;
   localparam int STAT_BAD_SPEED = 1;
   localparam int STAT_BAD_LOCK = 2;
   localparam int STAT_BAD_TCODE = 3;
   localparam int STAT_LOCK_LSB = 16;

endpackage

// *** core/asf_speed_decode.sv ***
// Speed code decoder: maps the 3-bit code to a link rate, flags reserved codes
`timescale 1ns/1ps
module asf_speed_decode (
   input wire logic [2:0] speed_code,
   output logic [1:0] rate,
   output logic reserved
);
   always_comb begin
      reserved = 1'b0;
      case (speed_code)
         asf_pkg::SPD_100: rate = asf_pkg::RATE_100;
         asf_pkg::SPD_200: rate = asf_pkg::RATE_200;
         asf_pkg::SPD_400: rate = asf_pkg::RATE_400;
         default: begin
            // Reserved code: fall back to the slowest rate
            rate = asf_pkg::RATE_100;
            reserved = 1'b1;
         end
      endcase
   end
endmodule // asf_speed_decode

// *** core/asf_pad_mask.sv ***
// Zero padding of the final payload quadlet
`timescale 1ns/1ps
module asf_pad_mask (
   input wire logic [31:0] data_in,
   input wire logic is_last,
   input wire logic [1:0] len_low,
   output logic [31:0] data_out
);
   always_comb begin
      data_out = data_in;
      if (is_last) begin
         case (len_low)
            2'h1: data_out = {data_in[31:24], 24'h000000};
            2'h2: data_out = {data_in[31:16], 16'h0000};
            2'h3: data_out = {data_in[31:8], 8'h00};
            default: data_out = data_in;
         endcase
      end
   end
endmodule // asf_pad_mask

// *** core/asf_tx_formatter.sv ***
// Transmit formatter for asynchronous responses and asynchronous stream packets
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module asf_tx_formatter (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic TXF_VALID,
   input wire logic [31:0] TXF_DATA,
   output logic TXF_READY,
   output logic ARB_REQ,
   input wire logic ARB_GRANT,
   output logic LNK_VALID,
   output logic [31:0] LNK_DATA,
   output logic LNK_LAST,
   output logic [1:0] LNK_SPEED,
   input wire logic LNK_READY
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_HDR = 5'h02,
      ST_ARB = 5'h04,
      ST_SEND = 5'h08,
      ST_DATA = 5'h10
   } asf_state_e;

   asf_state_e state_reg, state_next;
   logic [31:0] hdr_reg [0:3];
   logic [31:0] hdr_next [0:3];
   logic [1:0] idx_reg, idx_next;
   logic [14:0] rem_reg, rem_next;
   logic [1:0] ctrl_reg, ctrl_next;
   logic [15:0] node_reg, node_next;
   logic [3:0] sticky_reg, sticky_next;
   logic [15:0] lock_reg, lock_next;
   logic [31:0] count_reg, count_next;
   logic txf_ready_reg, txf_ready_next;
   logic arb_req_reg, arb_req_next;
   logic out_valid_reg, out_valid_next;
   logic [31:0] out_data_reg, out_data_next;
   logic out_last_reg, out_last_next;
   logic skid_valid_reg, skid_valid_next;
   logic [31:0] skid_data_reg, skid_data_next;
   logic skid_last_reg, skid_last_next;
   logic [1:0] speed_reg, speed_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [31:0] prdata_reg, prdata_next;

   // ----------------------------------------------------------------
   // Header field views
   // ----------------------------------------------------------------
   logic [3:0] tcode;
   logic is_stream;
   logic is_lock;
   logic is_block;
   logic is_quad;
   logic [1:0] hdr_last;
   logic [1:0] wire_last;
   logic [15:0] len;
   logic [14:0] quads;
   logic [15:0] lock_code;
   logic [1:0] retry;
   logic [15:0] source_id;
   logic [31:0] wire_word;
   logic [1:0] rate;
   logic speed_bad;
   logic [31:0] padded;
   logic fifo_take;
   logic can_push;
   logic push;
   logic [31:0] push_data;
   logic push_last;
   logic pop;
   logic apb_access;
   logic apb_write;
   logic apb_hit;
   logic [31:0] apb_rdata;

   assign tcode = hdr_reg[0][asf_pkg::Q0_TCODE_LSB +: 4];
   assign is_stream = (tcode == asf_pkg::TC_STREAM);
   assign is_lock = (tcode == asf_pkg::TC_LOCK_RESP);
   assign is_block = (tcode == asf_pkg::TC_BLOCK_RESP);
   assign is_quad = !(is_stream || is_lock || is_block);
   // Stream carries two internal header quadlets, responses four
   assign hdr_last = is_stream ? 2'h1 : 2'h3;
   // Stream header goes out as one quadlet; the length word is folded into it
   assign wire_last = is_stream ? 2'h0 : 2'h3;
   assign len = is_stream ? hdr_reg[1][asf_pkg::LEN_LSB +: 16] :
      (is_quad ? 16'h0000 : hdr_reg[3][asf_pkg::LEN_LSB +: 16]);
   assign quads = 15'((17'(len) + 17'h3) >> 2);
   assign lock_code = is_lock ? hdr_reg[3][15:0] : 16'h0000;
   assign retry = ctrl_reg[asf_pkg::CTRL_RETRY_SUB] ? asf_pkg::RETRY_X :
      hdr_reg[0][asf_pkg::Q0_RT_LSB +: 2];
   assign source_id = {(hdr_reg[0][asf_pkg::Q0_SRCSEL] ? node_reg[15:6] :
      asf_pkg::BUS_LOCAL), node_reg[5:0]};
   assign fifo_take = TXF_VALID && txf_ready_reg;
   assign can_push = !skid_valid_reg;
   assign pop = out_valid_reg && LNK_READY;

   asf_speed_decode u_speed (
      .speed_code(hdr_reg[0][asf_pkg::Q0_SPD_LSB +: 3]),
      .rate(rate),
      .reserved(speed_bad)
   );

   asf_pad_mask u_pad (
      .data_in(TXF_DATA),
      .is_last(rem_reg == 15'h0001),
      .len_low(len[1:0]),
      .data_out(padded)
   );

   // ----------------------------------------------------------------
   // Wire header assembly
   // ----------------------------------------------------------------
   always_comb begin
      wire_word = hdr_reg[idx_reg];
      if (is_stream) begin
         wire_word = {len, hdr_reg[0][asf_pkg::Q0_TAG_LSB +: 2],
            hdr_reg[0][asf_pkg::Q0_CHAN_LSB +: 6], tcode,
            hdr_reg[0][asf_pkg::Q0_SYNC_LSB +: 4]};
      end else begin
         case (idx_reg)
            2'h0: wire_word = {hdr_reg[1][asf_pkg::Q1_TARGET_LSB +: 16],
               hdr_reg[0][asf_pkg::Q0_TRANSACTION_LABEL_LSB +: 6], retry, tcode,
               asf_pkg::PRIORITY_ZERO};
            2'h1: wire_word = {source_id,
               hdr_reg[1][asf_pkg::Q1_RESPONSE_CODE_LSB +: 4], hdr_reg[1][11:0]};
            2'h2: wire_word = hdr_reg[2];
            default: wire_word = is_quad ? hdr_reg[3] : {len, lock_code};
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Packet sequencer and output stage
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      for (int i = 0; i < 4; i++) begin
         hdr_next[i] = hdr_reg[i];
      end
      idx_next = idx_reg;
      rem_next = rem_reg;
      arb_req_next = arb_req_reg;
      speed_next = speed_reg;
      count_next = count_reg;
      lock_next = lock_reg;
      // Events of this cycle only; merged with the held flags below
      sticky_next = 4'h0;
      push = 1'b0;
      push_data = 32'h00000000;
      push_last = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (fifo_take) begin
               hdr_next[0] = TXF_DATA;
               idx_next = 2'h1;
               state_next = ST_HDR;
            end
         end
         ST_HDR: begin
            if (fifo_take) begin
               hdr_next[idx_reg] = TXF_DATA;
               if (idx_reg == hdr_last) begin
                  idx_next = 2'h0;
                  state_next = ST_ARB;
               end else begin
                  idx_next = idx_reg + 2'h1;
               end
            end
         end
         ST_ARB: begin
            // Link drains first so the rate never changes under a packet
            if (!out_valid_reg) begin
               arb_req_next = 1'b1;
            end
            if (arb_req_reg && ARB_GRANT) begin
               arb_req_next = 1'b0;
               speed_next = rate;
               rem_next = quads;
               if (is_lock) begin
                  lock_next = hdr_reg[3][15:0];
               end
               sticky_next[asf_pkg::STAT_BAD_SPEED] = sticky_next[asf_pkg::STAT_BAD_SPEED]
                  | speed_bad;
               sticky_next[asf_pkg::STAT_BAD_LOCK] = sticky_next[asf_pkg::STAT_BAD_LOCK]
                  | (!is_lock && !is_quad && !is_stream && (hdr_reg[3][15:0] != 16'h0000));
               sticky_next[asf_pkg::STAT_BAD_TCODE] = sticky_next[asf_pkg::STAT_BAD_TCODE]
                  | (is_quad && (tcode != asf_pkg::TC_QUAD_RESP));
               state_next = ST_SEND;
            end
         end
         ST_SEND: begin
            if (can_push) begin
               push = 1'b1;
               push_data = wire_word;
               push_last = (idx_reg == wire_last) && (rem_reg == 15'h0000);
               if (idx_reg == wire_last) begin
                  idx_next = 2'h0;
                  // Payload follows the header with no idle slot
                  state_next = (rem_reg == 15'h0000) ? ST_IDLE : ST_DATA;
                  if (rem_reg == 15'h0000) begin
                     count_next = count_reg + 32'h00000001;
                  end
               end else begin
                  idx_next = idx_reg + 2'h1;
               end
            end
         end
         ST_DATA: begin
            if (fifo_take) begin
               push = 1'b1;
               push_data = padded;
               push_last = (rem_reg == 15'h0001);
               rem_next = rem_reg - 15'h0001;
               if (rem_reg == 15'h0001) begin
                  state_next = ST_IDLE;
                  count_next = count_reg + 32'h00000001;
               end
            end
         end
         default: state_next = ST_IDLE;
      endcase

      // Two-slot output: registered fifo ready lands one word late, the skid holds it
      out_valid_next = out_valid_reg;
      out_data_next = out_data_reg;
      out_last_next = out_last_reg;
      skid_valid_next = skid_valid_reg;
      skid_data_next = skid_data_reg;
      skid_last_next = skid_last_reg;
      if (pop) begin
         out_valid_next = skid_valid_reg;
         out_data_next = skid_data_reg;
         out_last_next = skid_last_reg;
         skid_valid_next = 1'b0;
      end
      if (push) begin
         if (!out_valid_next) begin
            out_valid_next = 1'b1;
            out_data_next = push_data;
            out_last_next = push_last;
         end else begin
            skid_valid_next = 1'b1;
            skid_data_next = push_data;
            skid_last_next = push_last;
         end
      end

      txf_ready_next = ((state_next == ST_IDLE) && ctrl_reg[asf_pkg::CTRL_ENABLE])
         || (state_next == ST_HDR)
         || ((state_next == ST_DATA) && !skid_valid_next);
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   assign apb_access = PSEL && PENABLE && !pready_reg;
   assign apb_write = PSEL && PENABLE && pready_reg && PWRITE && !pslverr_reg;

   always_comb begin
      apb_hit = 1'b1;
      case (PADDR)
         asf_pkg::OFS_CTRL: apb_rdata = {30'h00000000, ctrl_reg};
         asf_pkg::OFS_NODE: apb_rdata = {16'h0000, node_reg};
         asf_pkg::OFS_STAT: apb_rdata = {lock_reg, 12'h000, sticky_reg[3:1],
            (state_reg != ST_IDLE) || out_valid_reg};
         asf_pkg::OFS_COUNT: apb_rdata = count_reg;
         default: begin
            apb_rdata = 32'h00000000;
            apb_hit = 1'b0;
         end
      endcase
      pready_next = apb_access;
      pslverr_next = apb_access && !apb_hit;
      prdata_next = (apb_access && !PWRITE) ? apb_rdata : 32'h00000000;
      ctrl_next = ctrl_reg;
      node_next = node_reg;
      if (apb_write && (PADDR == asf_pkg::OFS_CTRL)) begin
         ctrl_next = PWDATA[1:0];
      end
      if (apb_write && (PADDR == asf_pkg::OFS_NODE)) begin
         node_next = PWDATA[15:0];
      end
   end

   // Write-one-to-clear on sticky flags; a same-cycle set survives
   logic [3:0] sticky_final;
   always_comb begin
      sticky_final = sticky_reg | sticky_next;
      if (apb_write && (PADDR == asf_pkg::OFS_STAT)) begin
         sticky_final = (sticky_reg & ~PWDATA[3:0]) | sticky_next;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         state_reg <= ST_IDLE;
         for (int i = 0; i < 4; i++) begin
            hdr_reg[i] <= 32'h00000000;
         end
         idx_reg <= 2'h0;
         rem_reg <= 15'h0000;
         ctrl_reg <= asf_pkg::CTRL_RESET;
         node_reg <= 16'h0000;
         sticky_reg <= 4'h0;
         lock_reg <= 16'h0000;
         count_reg <= 32'h00000000;
         txf_ready_reg <= 1'b0;
         arb_req_reg <= 1'b0;
         out_valid_reg <= 1'b0;
         out_data_reg <= 32'h00000000;
         out_last_reg <= 1'b0;
         skid_valid_reg <= 1'b0;
         skid_data_reg <= 32'h00000000;
         skid_last_reg <= 1'b0;
         speed_reg <= asf_pkg::RATE_100;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         state_reg <= state_next;
         for (int i = 0; i < 4; i++) begin
            hdr_reg[i] <= hdr_next[i];
         end
         idx_reg <= idx_next;
         rem_reg <= rem_next;
         ctrl_reg <= ctrl_next;
         node_reg <= node_next;
         sticky_reg <= sticky_final;
         lock_reg <= lock_next;
         count_reg <= count_next;
         txf_ready_reg <= txf_ready_next;
         arb_req_reg <= arb_req_next;
         out_valid_reg <= out_valid_next;
         out_data_reg <= out_data_next;
         out_last_reg <= out_last_next;
         skid_valid_reg <= skid_valid_next;
         skid_data_reg <= skid_data_next;
         skid_last_reg <= skid_last_next;
         speed_reg <= speed_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
      end
   end

   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = pslverr_reg;
   assign TXF_READY = txf_ready_reg;
   assign ARB_REQ = arb_req_reg;
   assign LNK_VALID = out_valid_reg;
   assign LNK_DATA = out_data_reg;
   assign LNK_LAST = out_last_reg;
   assign LNK_SPEED = speed_reg;

endmodule // asf_tx_formatter

// *** dv/asf_tx_formatter_asserts.sv ***
// Port-level checks for the transmit formatter
`timescale 1ns/1ps
module asf_tx_formatter_asserts (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic TXF_READY,
   input wire logic ARB_REQ,
   input wire logic ARB_GRANT,
   input wire logic LNK_VALID,
   input wire logic [31:0] LNK_DATA,
   input wire logic LNK_LAST,
   input wire logic [1:0] LNK_SPEED,
   input wire logic LNK_READY
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_B);
   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("PREADY missing after access phase");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("PREADY longer than one cycle");
   a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
      else $error("PRDATA nonzero outside answer");
   a_slverr_ready: assert property (PSLVERR |-> PREADY)
      else $error("PSLVERR without PREADY");
   // ----------------------------------------------------------------
   // Arbitration and link
   // ----------------------------------------------------------------
   a_req_holds: assert property (ARB_REQ && !ARB_GRANT |=> ARB_REQ)
      else $error("ARB_REQ dropped before grant");
   a_grant_start: assert property (ARB_REQ && ARB_GRANT |=>
      !ARB_REQ && !LNK_VALID ##1 LNK_VALID)
      else $error("Packet start not two edges after grant");
   a_fifo_closed: assert property (ARB_REQ |-> !TXF_READY)
      else $error("FIFO open while arbitrating");
   a_link_hold: assert property (LNK_VALID && !LNK_READY |=> LNK_VALID &&
      $stable(LNK_DATA) && $stable(LNK_LAST) && $stable(LNK_SPEED))
      else $error("Link quadlet changed before taken");
   a_no_gap: assert property (LNK_VALID && LNK_READY && !LNK_LAST |=> LNK_VALID)
      else $error("Gap inside packet");
   a_speed_legal: assert property (LNK_VALID |-> LNK_SPEED != 2'h3)
      else $error("Reserved link rate");
   c_grant: cover property (ARB_REQ && ARB_GRANT);
   c_stall: cover property (LNK_VALID && !LNK_READY);
   c_last: cover property (LNK_VALID && LNK_READY && LNK_LAST);
   c_slverr: cover property (PSLVERR);
endmodule // asf_tx_formatter_asserts

bind asf_tx_formatter asf_tx_formatter_asserts u_chk (.CLOCK, .RST_B, .PSEL, .PENABLE,
   .PRDATA, .PREADY, .PSLVERR, .TXF_READY, .ARB_REQ, .ARB_GRANT, .LNK_VALID,
   .LNK_DATA, .LNK_LAST, .LNK_SPEED, .LNK_READY);

// *** dv/asf_far_model.sv ***
// Far side: transmit DMA source, link arbiter and link sink
`timescale 1ns/1ps
module asf_far_model (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic slow,
   input wire logic TXF_READY,
   input wire logic ARB_REQ,
   input wire logic LNK_VALID,
   input wire logic [31:0] LNK_DATA,
   input wire logic LNK_LAST,
   input wire logic [1:0] LNK_SPEED,
   output logic TXF_VALID,
   output logic [31:0] TXF_DATA,
   output logic ARB_GRANT,
   output logic LNK_READY
);
   logic [31:0] txq[$];
   logic [34:0] rxq[$];
   initial begin
      TXF_VALID = 1'b0;
      TXF_DATA = 32'h0;
      ARB_GRANT = 1'b0;
      LNK_READY = 1'b0;
   end
   // Whole packets sit in the queue, so the source never stalls mid-packet
   always @(posedge CLOCK) begin
      if (!RST_B) begin
         TXF_VALID <= 1'b0;
         ARB_GRANT <= 1'b0;
         LNK_READY <= 1'b0;
      end else begin
         if (TXF_VALID && TXF_READY)
            void'(txq.pop_front());
         TXF_VALID <= txq.size() > 0;
         // Idle data inverted so stale words never look valid
         TXF_DATA <= txq.size() > 0 ? txq[0] : ~TXF_DATA;
         ARB_GRANT <= ARB_REQ && !ARB_GRANT && (!slow || $urandom % 2 == 1);
         LNK_READY <= !slow || $urandom % 2 == 1;
         if (LNK_VALID && LNK_READY)
            rxq.push_back({LNK_SPEED, LNK_LAST, LNK_DATA});
      end
   end
endmodule // asf_far_model

// *** dv/asf_tx_formatter_test.sv ***
// Self-checking bench for the transmit formatter
`timescale 1ns/1ps
module asf_tx_formatter_test;
   logic CLOCK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, slow = 0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, TXF_DATA, LNK_DATA, rd;
   logic PREADY, PSLVERR, TXF_VALID, TXF_READY, ARB_REQ, ARB_GRANT;
   logic LNK_VALID, LNK_LAST, LNK_READY, er, rsub = 0, bs = 0, bl = 0;
   logic [1:0] LNK_SPEED, rate_x;
   logic [15:0] nd, lkx = 16'h0;
   logic [34:0] exp_q[$];
   logic [3:0] tcs[4] = '{asf_pkg::TC_QUAD_RESP, asf_pkg::TC_BLOCK_RESP,
      asf_pkg::TC_LOCK_RESP, asf_pkg::TC_STREAM};
   int err_count = 0, cmp_count = 0, cyc = 0, pk = 0;

   asf_tx_formatter u_dut (.CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TXF_VALID(TXF_VALID),
      .TXF_DATA(TXF_DATA), .TXF_READY(TXF_READY), .ARB_REQ(ARB_REQ),
      .ARB_GRANT(ARB_GRANT), .LNK_VALID(LNK_VALID), .LNK_DATA(LNK_DATA),
      .LNK_LAST(LNK_LAST), .LNK_SPEED(LNK_SPEED), .LNK_READY(LNK_READY));
   asf_far_model u_far (.CLOCK(CLOCK), .RST_B(RST_B), .slow(slow),
      .TXF_READY(TXF_READY), .ARB_REQ(ARB_REQ), .LNK_VALID(LNK_VALID),
      .LNK_DATA(LNK_DATA), .LNK_LAST(LNK_LAST), .LNK_SPEED(LNK_SPEED),
      .TXF_VALID(TXF_VALID), .TXF_DATA(TXF_DATA), .ARB_GRANT(ARB_GRANT),
      .LNK_READY(LNK_READY));

   initial begin
      forever #20 CLOCK = ~CLOCK;
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge CLOCK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic check(input logic [34:0] seen, input logic [34:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Entered just after an edge; one idle cycle follows each transfer
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do @(posedge CLOCK); while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLOCK);
   endtask
   task automatic ex(input logic [31:0] x);
      exp_q.push_back({rate_x, 1'b0, x});
   endtask
   task automatic send(input logic [3:0] tc, input int len);
      logic [31:0] r, lk, q2, w;
      logic [2:0] spd;
      logic [1:0] rt;
      r = $urandom;
      lk = $urandom;
      q2 = $urandom;
      spd = r[2:0];
      rate_x = spd > 3'h2 ? 2'h0 : spd[1:0];
      rt = rsub ? asf_pkg::RETRY_X : r[11:10];
      bs |= spd > 3'h2;
      pk++;
      if (tc == asf_pkg::TC_STREAM) begin
         u_far.txq.push_back({13'h0, spd, r[27:20], tc, r[15:12]});
         u_far.txq.push_back({len[15:0], 16'h0});
         ex({len[15:0], r[27:20], tc, r[15:12]});
      end else begin
         u_far.txq.push_back({8'h0, r[3], 4'h0, spd, r[9:4], r[11:10], tc, 4'h0});
         u_far.txq.push_back({lk[31:16], r[15:12], lk[11:0]});
         u_far.txq.push_back(q2);
         u_far.txq.push_back(tc == asf_pkg::TC_QUAD_RESP ? lk : {len[15:0], lk[15:0]});
         ex({lk[31:16], r[9:4], rt, tc, 4'h0});
         ex({r[3] ? nd[15:6] : asf_pkg::BUS_LOCAL, nd[5:0], r[15:12], lk[11:0]});
         ex(q2);
         ex(tc == asf_pkg::TC_QUAD_RESP ? lk :
            {len[15:0], tc == asf_pkg::TC_LOCK_RESP ? lk[15:0] : 16'h0});
         bl |= tc == asf_pkg::TC_BLOCK_RESP && lk[15:0] != 16'h0;
         if (tc == asf_pkg::TC_LOCK_RESP)
            lkx = lk[15:0];
      end
      if (tc != asf_pkg::TC_QUAD_RESP)
         for (int i = 0; i < (len + 3) / 4; i++) begin
            w = $urandom;
            u_far.txq.push_back(w);
            ex(len - 4 * i < 4 ? w & ~(32'hffffffff >> (8 * (len - 4 * i))) : w);
         end
      exp_q[$][32] = 1'b1;
   endtask
   task automatic drain();
      int n;
      n = 0;
      while (u_far.rxq.size() < exp_q.size() && n < 3000) begin
         @(posedge CLOCK);
         n++;
      end
      while (exp_q.size() > 0)
         check(u_far.rxq.size() > 0 ? u_far.rxq.pop_front() : 35'h0, exp_q.pop_front());
      repeat (4) @(posedge CLOCK);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h24deb8db));
      repeat (6) @(posedge CLOCK);
      RST_B <= 1'b1;
      @(posedge CLOCK);
      apb(1'b0, asf_pkg::OFS_CTRL, 32'h0);
      check({er, rd}, 35'h1);
      apb(1'b0, 8'h10, 32'h0);
      check({er, rd}, 35'h100000000);
      nd = $urandom;
      apb(1'b1, asf_pkg::OFS_NODE, {16'h0, nd});
      apb(1'b0, asf_pkg::OFS_NODE, 32'h0);
      check(rd[15:0], nd);
      for (int i = 0; i < 16; i++) begin
         slow <= i[1];
         if (i == 8) begin
            apb(1'b1, asf_pkg::OFS_CTRL, 32'h3);
            rsub = 1'b1;
         end
         // Two packets queued back to back, lengths across every remainder
         send(tcs[i % 4], i % 5);
         send(tcs[(i + 1) % 4], $urandom % 13);
         drain();
      end
      apb(1'b0, asf_pkg::OFS_COUNT, 32'h0);
      check(rd, pk);
      apb(1'b0, asf_pkg::OFS_STAT, 32'h0);
      check({rd[31:16], rd[3:0]}, {lkx, 1'b0, bl, bs, 1'b0});
      apb(1'b1, asf_pkg::OFS_STAT, 32'he);
      apb(1'b0, asf_pkg::OFS_STAT, 32'h0);
      check(rd[3:0], 4'h0);
      end_of_test();
   end
endmodule // asf_tx_formatter_test
